// ==== logic/adc_cfg_pkg.sv ====
package adc_cfg_pkg;

  // register indices on the serial command port (address bits 15:9)
  localparam logic [6:0] SCAN_EN_ADDR  = 7'h01;
  localparam logic [6:0] PWR_DN_ADDR   = 7'h02;
  localparam logic [6:0] FEATURE_ADDR  = 7'h03;

  // reset values
  localparam logic [7:0] SCAN_EN_RST   = 8'hff;
  localparam logic [7:0] PWR_DN_RST    = 8'h00;
  localparam logic [1:0] CHAIN_ID_RST  = 2'h0;
  localparam logic [2:0] FORMAT_RST    = 3'h0;

  // feature register layout
  localparam int         CHAIN_ID_MSB  = 7;
  localparam int         CHAIN_ID_LSB  = 6;
  localparam int         FIXED_MSB     = 5;
  localparam int         FIXED_LSB     = 3;
  localparam int         FORMAT_MSB    = 2;
  localparam logic [2:0] FEATURE_FIXED = 3'h5;

  // channel implementation masks for the two variants
  localparam logic [7:0] IMPL_EIGHT    = 8'hff;
  localparam logic [7:0] IMPL_FOUR     = 8'h0f;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // output frame layout
  localparam int         FRAME_BITS    = 25;
  localparam int         RESULT_LSB    = 9;
  localparam int         CHAN_LSB      = 5;
  localparam int         DEVADR_LSB    = 3;
  localparam logic [4:0] LOAD_EDGE     = 5'h0f;  // count before the 16th falling edge
  localparam logic [4:0] EDGE_SAT      = 5'h10;

  typedef enum logic [2:0] {
    FMT_RESULT_ONLY = 3'b000,
    FMT_CHAN_ADDR   = 3'b001,
    FMT_DEV_ADDR    = 3'b010,
    FMT_RANGE       = 3'b011
  } frame_format_e;

endpackage : adc_cfg_pkg

// ==== logic/adc_scan_and_output_config.sv ====
`timescale 1ns/100ps

// How it works
// - scan-enable bit n includes channel n in the automatic scan; resets to all ones.
// - power-down register has one bit per channel, resets to zero, all front ends on.
// - a set power-down bit turns the front end off and bars the channel from scanning.
// - on the four-channel variant upper bits ignore writes and read back as ones.
// - feature bits 7:6 hold the daisy-chain position 0 to 3; reset zero.
// - feature bits 5:3 read constant 1,0,1; host must write those same values.
// - feature bits 2:0 hold the output frame format, read-write, reset zero.
// - conversion result goes out MSB-first in frame bits 24:9 from the 16th falling edge.
// - formats 000..011 add channel address, device address, then range; unused bits low.
// - automatic mode scans enabled, powered, present channels in ascending order, a new one per conversion; it holds when no other is eligible.
// - bit 8 is low, bits 7:5 hold the binary channel index, 4:3 device address, 2:0 range code.
module adc_scan_and_output_config #(
  parameter bit EIGHT_CHANNEL = 1'b1
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        reg_reset,
  input  wire logic        wr_en,
  input  wire logic [6:0]  wr_addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        rd_en,
  input  wire logic [6:0]  rd_addr,
  output logic      [7:0]  rd_data,
  input  wire logic        auto_scan_mode,
  input  wire logic        frame_start,
  input  wire logic        sclk_fall,
  input  wire logic [15:0] conv_result,
  input  wire logic [2:0]  range_code,
  output logic      [2:0]  active_channel,
  output logic      [7:0]  scan_channel_enable,
  output logic      [7:0]  chan_frontend_off,
  output logic      [1:0]  chain_position_id,
  output logic      [2:0]  output_frame_format,
  output logic             serial_data_out
);

  localparam logic [7:0] IMPL = EIGHT_CHANNEL ? adc_cfg_pkg::IMPL_EIGHT : adc_cfg_pkg::IMPL_FOUR;

  // next eligible channel above cur, wrapping; holds cur when nothing is eligible
  function automatic logic [2:0] next_chan(input logic [2:0] cur, input logic [7:0] elig);
    logic [2:0] idx;
    logic [2:0] pick;
    logic       found;
    pick  = cur;
    found = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      idx = 3'(cur + 3'(i));
      if (!found && elig[idx]) begin
        pick  = idx;
        found = 1'b1;
      end
    end
    return pick;
  endfunction : next_chan

  logic [7:0]  scan_en_q, scan_en_d;
  logic [7:0]  pwr_dn_q,  pwr_dn_d;
  logic [1:0]  chain_id_q, chain_id_d;
  logic [2:0]  format_q,  format_d;
  logic [7:0]  rd_data_q, rd_data_d;
  logic [2:0]  active_q,  active_d;
  logic [2:0]  frame_chan_q, frame_chan_d;
  logic [4:0]  edge_cnt_q, edge_cnt_d;
  logic [24:0] shift_q,   shift_d;
  logic [7:0]  eligible;
  logic        load_frame;
  logic [8:0]  tail;

  // a channel is scanned only if enabled, powered and present
  assign eligible = scan_en_q & ~pwr_dn_q & IMPL;

  // configuration registers: only implemented bits take writes
  always_comb begin
    scan_en_d  = scan_en_q;
    pwr_dn_d   = pwr_dn_q;
    chain_id_d = chain_id_q;
    format_d   = format_q;
    if (reg_reset) begin
      scan_en_d  = adc_cfg_pkg::SCAN_EN_RST;
      pwr_dn_d   = adc_cfg_pkg::PWR_DN_RST;
      chain_id_d = adc_cfg_pkg::CHAIN_ID_RST;
      format_d   = adc_cfg_pkg::FORMAT_RST;
    end else if (wr_en) begin
      unique case (wr_addr)
        adc_cfg_pkg::SCAN_EN_ADDR: scan_en_d = (wr_data & IMPL) | (scan_en_q & ~IMPL);
        adc_cfg_pkg::PWR_DN_ADDR:  pwr_dn_d  = (wr_data & IMPL) | (pwr_dn_q & ~IMPL);
        adc_cfg_pkg::FEATURE_ADDR: begin
          chain_id_d = wr_data[adc_cfg_pkg::CHAIN_ID_MSB:adc_cfg_pkg::CHAIN_ID_LSB];
          format_d   = wr_data[adc_cfg_pkg::FORMAT_MSB:0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      scan_en_q  <= adc_cfg_pkg::SCAN_EN_RST;
      pwr_dn_q   <= adc_cfg_pkg::PWR_DN_RST;
      chain_id_q <= adc_cfg_pkg::CHAIN_ID_RST;
      format_q   <= adc_cfg_pkg::FORMAT_RST;
    end else begin
      scan_en_q  <= scan_en_d;
      pwr_dn_q   <= pwr_dn_d;
      chain_id_q <= chain_id_d;
      format_q   <= format_d;
    end
  end

  // read-back: absent channel bits read as ones, fixed feature bits as 101
  always_comb begin
    rd_data_d = rd_data_q;
    if (rd_en) begin
      unique case (rd_addr)
        adc_cfg_pkg::SCAN_EN_ADDR: rd_data_d = scan_en_q | ~IMPL;
        adc_cfg_pkg::PWR_DN_ADDR:  rd_data_d = pwr_dn_q | ~IMPL;
        adc_cfg_pkg::FEATURE_ADDR: rd_data_d = {chain_id_q, adc_cfg_pkg::FEATURE_FIXED, format_q};
        default:                   rd_data_d = adc_cfg_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data_q <= adc_cfg_pkg::UNMAPPED_READ;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  // scanner: the frame converts the current channel; in auto mode the next one is chosen at once
  always_comb begin
    active_d     = active_q;
    frame_chan_d = frame_chan_q;
    if (frame_start) begin
      frame_chan_d = active_q;
      if (auto_scan_mode) begin
        active_d = next_chan(active_q, eligible);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      active_q     <= 3'h0;
      frame_chan_q <= 3'h0;
    end else begin
      active_q     <= active_d;
      frame_chan_q <= frame_chan_d;
    end
  end

  // frame tail by format; codes above 011 are treated like 000
  always_comb begin
    tail = 9'h000;
    unique case (format_q)
      adc_cfg_pkg::FMT_CHAN_ADDR: tail = {1'b0, frame_chan_q, 5'h00};
      adc_cfg_pkg::FMT_DEV_ADDR:  tail = {1'b0, frame_chan_q, chain_id_q, 3'h0};
      adc_cfg_pkg::FMT_RANGE:     tail = {1'b0, frame_chan_q, chain_id_q, range_code};
      default:                    tail = 9'h000;
    endcase
  end

  assign load_frame = sclk_fall && (edge_cnt_q == adc_cfg_pkg::LOAD_EDGE);

  // shifter: loads on the 16th falling edge, no latency, then one bit per edge
  always_comb begin
    edge_cnt_d = edge_cnt_q;
    shift_d    = shift_q;
    if (frame_start) begin
      edge_cnt_d = 5'h00;
      shift_d    = 25'h000_0000;
    end else if (sclk_fall) begin
      if (edge_cnt_q != adc_cfg_pkg::EDGE_SAT) begin
        edge_cnt_d = 5'(edge_cnt_q + 5'h01);
      end
      if (load_frame) begin
        shift_d = {conv_result, tail};
      end else begin
        shift_d = {shift_q[23:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      edge_cnt_q <= 5'h00;
      shift_q    <= 25'h000_0000;
    end else begin
      edge_cnt_q <= edge_cnt_d;
      shift_q    <= shift_d;
    end
  end

  assign rd_data             = rd_data_q;
  assign active_channel      = active_q;
  assign scan_channel_enable = scan_en_q;
  assign chan_frontend_off   = pwr_dn_q;
  assign chain_position_id   = chain_id_q;
  assign output_frame_format = format_q;
  assign serial_data_out     = shift_q[24];

  // guards on the register file, the scanner and the frame shifter
  AST_SCAN_RESET: assert property (@(posedge clock) $fell(rst) |-> scan_en_q == adc_cfg_pkg::SCAN_EN_RST)
    else $error("scan enable not all ones after reset");
  AST_PWR_RESET: assert property (@(posedge clock) $fell(rst) |-> pwr_dn_q == adc_cfg_pkg::PWR_DN_RST)
    else $error("power-down not zero after reset");
  // the channel moved to must have been eligible in the cycle it was picked
  AST_ELIGIBLE: assert property (@(posedge clock) disable iff (rst)
    active_q != $past(active_q) |-> (($past(eligible) >> active_q) & 8'h01) == 8'h01)
    else $error("scanner moved to an ineligible channel");
  AST_UPPER_ONES: assert property (@(posedge clock) disable iff (rst)
    rd_en && (rd_addr == adc_cfg_pkg::SCAN_EN_ADDR || rd_addr == adc_cfg_pkg::PWR_DN_ADDR)
    |=> (rd_data & ~IMPL) == ~IMPL)
    else $error("absent channel bits did not read as ones");
  AST_CHAIN_WRITE: assert property (@(posedge clock) disable iff (rst)
    wr_en && !reg_reset && wr_addr == adc_cfg_pkg::FEATURE_ADDR
    |=> chain_id_q == $past(wr_data[adc_cfg_pkg::CHAIN_ID_MSB:adc_cfg_pkg::CHAIN_ID_LSB]))
    else $error("chain id not taken from write");
  AST_FIXED_BITS: assert property (@(posedge clock) disable iff (rst)
    rd_en && rd_addr == adc_cfg_pkg::FEATURE_ADDR
    |=> rd_data[adc_cfg_pkg::FIXED_MSB:adc_cfg_pkg::FIXED_LSB] == adc_cfg_pkg::FEATURE_FIXED)
    else $error("fixed feature bits read wrong");
  AST_FORMAT_WRITE: assert property (@(posedge clock) disable iff (rst)
    wr_en && !reg_reset && wr_addr == adc_cfg_pkg::FEATURE_ADDR
    |=> format_q == $past(wr_data[adc_cfg_pkg::FORMAT_MSB:0]))
    else $error("format not taken from write");
  // eight quiet cycles hold at most eight falling edges, well short of the 16th
  AST_SILENT_HEAD: assert property (@(posedge clock) disable iff (rst)
    frame_start ##1 (!frame_start)[*8] |-> !serial_data_out)
    else $error("output drove before the 16th edge");
  AST_MSB_FIRST: assert property (@(posedge clock) disable iff (rst)
    load_frame && !frame_start |=> serial_data_out == $past(conv_result[15]))
    else $error("frame did not start with result msb");
  AST_FMT0_LOW: assert property (@(posedge clock) disable iff (rst)
    load_frame && !frame_start && format_q == adc_cfg_pkg::FMT_RESULT_ONLY |=> shift_q[8:0] == 9'h000)
    else $error("format 000 tail not low");
  AST_HOLD_NONE: assert property (@(posedge clock) disable iff (rst)
    frame_start && auto_scan_mode && eligible == 8'h00 |=> active_q == $past(active_q))
    else $error("scanner moved with no eligible channel");

endmodule : adc_scan_and_output_config

// ==== tb/frame_host.sv ====
`timescale 1ns/100ps

// host side of the serial frame: marks the frame, clocks it, captures the output bits
module frame_host (
  input  wire logic        clock,
  input  wire logic        serial_data_out,
  output logic             frame_start,
  output logic             sclk_fall,
  output logic      [24:0] frame_bits
);
  initial begin
    frame_start = 1'b0;
    sclk_fall = 1'b0;
    frame_bits = '0;
  end

  // a gap cycle after each falling edge gives the shifted bit time to settle
  task automatic run_frame();
    frame_bits = '0;
    @(posedge clock);
    #1 frame_start = 1'b1;
    @(posedge clock);
    #1 frame_start = 1'b0;
    for (int i = 0; i < 40; i++) begin
      sclk_fall = 1'b1;
      @(posedge clock);
      #1 sclk_fall = 1'b0;
      @(posedge clock);
      #1;
      if (i >= 15) begin
        frame_bits = {frame_bits[23:0], serial_data_out};
      end
    end
  endtask : run_frame
endmodule : frame_host

// ==== tb/testbench.sv ====
`timescale 1ns/100ps

module testbench;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        reg_reset = 1'b0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [6:0]  wr_addr = 7'h00;
  logic [6:0]  rd_addr = 7'h00;
  logic [7:0]  wr_data = 8'h00;
  logic [15:0] conv_result = 16'ha5c3;
  logic [2:0]  range_code = 3'h5;
  logic        auto_scan_mode = 1'b1;
  logic        frame_start, sclk_fall, serial_data_out;
  logic [24:0] frame_bits;
  logic [7:0]  rd_data, rd_data_four, scan_channel_enable, chan_frontend_off;
  logic [2:0]  active_channel, output_frame_format, exp_ch;
  logic [1:0]  chain_position_id;
  logic [8:0]  mask;
  int          n_errors = 0;
  int          check_count = 0;

  always #50 clock = ~clock;

  // eight-channel device under test plus a four-channel twin on the same inputs
  adc_scan_and_output_config adc_scan_and_output_config_inst (.clock, .rst, .reg_reset, .wr_en, .wr_addr,
    .wr_data, .rd_en, .rd_addr, .rd_data, .auto_scan_mode, .frame_start, .sclk_fall, .conv_result,
    .range_code, .active_channel, .scan_channel_enable, .chan_frontend_off, .chain_position_id,
    .output_frame_format, .serial_data_out);
  adc_scan_and_output_config #(.EIGHT_CHANNEL(1'b0)) adc_scan_and_output_config_four_inst (.clock, .rst,
    .reg_reset, .wr_en, .wr_addr, .wr_data, .rd_en, .rd_addr, .rd_data(rd_data_four), .auto_scan_mode,
    .frame_start, .sclk_fall, .conv_result, .range_code, .active_channel(), .scan_channel_enable(),
    .chan_frontend_off(), .chain_position_id(), .output_frame_format(), .serial_data_out());
  frame_host frame_host_inst (.clock, .serial_data_out, .frame_start, .sclk_fall, .frame_bits);

  task automatic check(input logic [24:0] seen, input logic [24:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(posedge clock);
    #1 wr_en = 1'b0;
  endtask : wr

  // read data is registered, so it is looked at once the next edge has landed
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clock);
    #1 rd_en = 1'b1;
    rd_addr = a;
    @(posedge clock);
    #1 rd_en = 1'b0;
    check(25'(rd_data), 25'(exp));
  endtask : rd

  task automatic conclude();
    if (n_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (16) @(posedge clock);
    #1 rst = 1'b0;
    rd(7'h01, 8'hff);
    rd(7'h02, 8'h00);
    rd(7'h03, 8'h28);
    rd(7'h04, 8'h00);
    // the host always writes the fixed bits as 101, as the device expects
    wr(7'h03, 8'he8);
    rd(7'h03, 8'he8);
    check(25'(chain_position_id), 25'(2'h3));
    wr(7'h01, 8'h0d);
    wr(7'h02, 8'h04);
    rd(7'h01, 8'h0d);
    check(25'(rd_data_four), 25'(8'hfd));
    rd(7'h02, 8'h04);
    check(25'(rd_data_four), 25'(8'hf4));
    check(25'(chan_frontend_off), 25'(8'h04));
    // channel 2 is enabled but powered down, so the scan alternates 0 and 3
    exp_ch = 3'h0;
    for (int f = 0; f < 5; f++) begin
      wr(7'h03, {2'h2, 3'h5, f[2:0]});
      check(25'(output_frame_format), 25'(f[2:0]));
      mask = (f == 1) ? 9'h1e0 : (f == 2) ? 9'h1f8 : (f == 3) ? 9'h1ff : 9'h000;
      conv_result = ~conv_result;
      frame_host_inst.run_frame();
      check(frame_bits, {conv_result, mask & {1'b0, exp_ch, 2'h2, range_code}});
      exp_ch = (exp_ch == 3'h0) ? 3'h3 : 3'h0;
      check(25'(active_channel), 25'(exp_ch));
    end
    // nothing eligible: the scanner must stay on channel 3
    wr(7'h02, 8'h0d);
    frame_host_inst.run_frame();
    check(25'(active_channel), 25'(exp_ch));
    @(posedge clock);
    #1 reg_reset = 1'b1;
    @(posedge clock);
    #1 reg_reset = 1'b0;
    check(25'(scan_channel_enable), 25'(8'hff));
    check(25'(chan_frontend_off), 25'(8'h00));
    rd(7'h03, 8'h28);
    // manual mode leaves the scanner alone; auto mode then climbs from 3 to 4
    auto_scan_mode = 1'b0;
    frame_host_inst.run_frame();
    check(25'(active_channel), 25'(3'h3));
    check(frame_bits, {conv_result, 9'h000});
    auto_scan_mode = 1'b1;
    frame_host_inst.run_frame();
    check(25'(active_channel), 25'(3'h4));
    // a second reset in mid-run returns scanner, read data and enables to their start values
    @(posedge clock);
    #1 rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    check(25'(active_channel), 25'(3'h0));
    check(25'(rd_data), 25'(8'h00));
    check(25'(scan_channel_enable), 25'(8'hff));
    conclude();
  end
endmodule : testbench
